// ==== common/sbw_pkg.sv ====
// Purpose: Shared constants and types for the SRAM byte-write control block.
// Assumes: Wide variant with four byte lanes, each lane a data byte plus one parity bit.
// Notes:   Storage depth is kept small; the address pipeline beyond a short index is not modelled.
package sbw_pkg;

  localparam int SBW_LANES = 4;
  localparam int SBW_BYTE_W = 8;
  localparam int SBW_LANE_W = SBW_BYTE_W + 1;
  localparam int SBW_DATA_W = SBW_LANES * SBW_BYTE_W;
  localparam int SBW_WORD_W = SBW_LANES * SBW_LANE_W;
  localparam int SBW_ADDR_W = 4;
  localparam int SBW_DEPTH = 16;
  localparam int SBW_BURST_W = 2;
  localparam int SBW_FIFO_DEPTH = 8;
  localparam int SBW_ENTRY_W = SBW_ADDR_W + SBW_LANES + SBW_WORD_W;

  localparam logic [SBW_LANES-1:0] SBW_LANES_NONE_N = 4'hF;
  localparam logic [SBW_WORD_W-1:0] SBW_WORD_RESET = 36'h0;
  localparam logic [SBW_ADDR_W-1:0] SBW_ADDR_RESET = 4'h0;
  localparam logic [SBW_BURST_W-1:0] SBW_BURST_STEP = 2'h1;

  // Operation carried down the pipeline, one-hot.
  typedef enum logic [2:0] {
    SBW_OP_IDLE  = 3'b001,
    SBW_OP_READ  = 3'b010,
    SBW_OP_WRITE = 3'b100
  } sbw_op_t;

endpackage

// ==== logic/sbw_fifo.sv ====
// Purpose: Parameterised flip-flop FIFO with valid and ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes:   A push into a full FIFO is refused; in_ready tells the source.
`timescale 1ns/1ns
`default_nettype none
module sbw_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_n,
  // Filling side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0] count_r;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;

  assign in_ready = (count_r != DEPTH[PW:0]);
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];

  always_ff @(posedge clock)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r <= count_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    end
  end

endmodule // sbw_fifo
`default_nettype wire

// ==== logic/sbw_core.sv ====
// Purpose: Byte-write and data-pin drive control of a pipelined burst SRAM.
// Assumes: All pin inputs except output enable are synchronous to clock; one clock domain.
// Notes:   Writes pass through an eight-entry buffer before reaching storage.
// Operation
// [RL1] A write is write request low plus lane selects; request high means read.
// [RL2] A write stores data when any lane select is low with write request.
// [RL3] Any lane select pattern is legal; exactly the low-select lanes are stored.
// [RL4] Each lane select gates its own byte and parity bit only.
// [RL5] Write request low with all selects high runs a write storing nothing.
// [RL6] A detected write floats all data and parity pins, partial writes too.
// [RL7] Pin drive follows the current cycle's operation and output enable.
// [RL8] Clock qualifier high ignores the edge and extends the previous cycle.
// [RL9] After power-up the block is deselected and its pins float.
// [RL10] Output enable acts on drivers asynchronously, never sampled by the clock.
// [RL11] Output enable is masked during write cycles.
// [RL12] Reads drive data only while output enable active; else pins float.
// [RL13] Controller presents write data at second edge after the write command.
// [RL14] Controller drives correct lane selects in every burst beat.
// [RL15] Unselected lanes keep their stored values after a partial write.
`timescale 1ns/1ns
`default_nettype none
module sbw_core
  import sbw_pkg::*;
(
  // Clock and reset.
  input wire logic clock,
  input wire logic arst_n,
  // Command pins.
  input wire logic clock_qualifier_n,
  input wire logic chip_enable_n,
  input wire logic advance_or_load,
  input wire logic write_request_n,
  input wire logic [sbw_pkg::SBW_LANES-1:0] lane_write_selects_n,
  input wire logic [sbw_pkg::SBW_ADDR_W-1:0] address,
  input wire logic output_enable_n,
  // Data and parity pins, split into input, output and enable.
  input wire logic [sbw_pkg::SBW_DATA_W-1:0] data_pins_in,
  input wire logic [sbw_pkg::SBW_LANES-1:0] parity_pins_in,
  output logic [sbw_pkg::SBW_DATA_W-1:0] data_pins_out,
  output logic [sbw_pkg::SBW_LANES-1:0] parity_pins_out,
  output logic data_pins_oe,
  // Write buffer status.
  output logic write_buffer_full
);

  import sbw_pkg::*;

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_sync1_r;
  logic rst_n_r;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rst_sync1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_sync1_r <= 1'b1;
      rst_n_r <= rst_sync1_r;
    end
  end

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  sbw_op_t op1_r;
  sbw_op_t op2_r;
  sbw_op_t op1_nxt;
  logic [SBW_ADDR_W-1:0] addr1_r;
  logic [SBW_ADDR_W-1:0] addr2_r;
  logic [SBW_ADDR_W-1:0] addr1_nxt;
  logic [SBW_LANES-1:0] sel1_r;
  logic [SBW_LANES-1:0] sel2_r;

  // A stalled edge changes nothing in the pipeline.
  wire edge_taken = !clock_qualifier_n; // RL8
  wire load_cmd = !advance_or_load;
  wire new_write = !write_request_n; // RL1
  // Byte selects are don't-care on reads, so they are not looked at there.
  wire sel_none = (lane_write_selects_n == SBW_LANES_NONE_N);

  // Burst continuation steps the low address bits and keeps the operation.
  wire [SBW_BURST_W-1:0] burst_low = addr1_r[SBW_BURST_W-1:0] + SBW_BURST_STEP;
  wire [SBW_ADDR_W-1:0] burst_addr = {addr1_r[SBW_ADDR_W-1:SBW_BURST_W], burst_low};

  assign op1_nxt = !load_cmd ? op1_r :
                   chip_enable_n ? SBW_OP_IDLE :
                   new_write ? SBW_OP_WRITE : SBW_OP_READ; // RL1
  assign addr1_nxt = load_cmd ? address : burst_addr;

  // ---------------------------------------------------------------
  // Pipeline
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      op1_r <= SBW_OP_IDLE; // RL9
      op2_r <= SBW_OP_IDLE; // RL9
      addr1_r <= SBW_ADDR_RESET;
      addr2_r <= SBW_ADDR_RESET;
      sel1_r <= SBW_LANES_NONE_N;
      sel2_r <= SBW_LANES_NONE_N;
    end
    else if (edge_taken) // RL8
    begin
      op1_r <= op1_nxt;
      op2_r <= op1_r;
      addr1_r <= addr1_nxt;
      addr2_r <= addr1_r;
      // Lane selects are sampled fresh on every beat, burst beats included.
      sel1_r <= lane_write_selects_n; // RL14
      sel2_r <= sel1_r;
    end
  end

  // ---------------------------------------------------------------
  // Write data capture and buffer
  // ---------------------------------------------------------------
  logic [SBW_WORD_W-1:0] pin_word;
  logic [SBW_ENTRY_W-1:0] push_entry;
  logic [SBW_ENTRY_W-1:0] pop_entry;
  logic fifo_in_ready;
  logic fifo_out_valid;

  genvar g;
  generate
    for (g = 0; g < SBW_LANES; g++)
    begin : g_pack
      // Each lane carries its byte with its own parity bit.
      assign pin_word[g*SBW_LANE_W +: SBW_LANE_W] =
        {parity_pins_in[g], data_pins_in[g*SBW_BYTE_W +: SBW_BYTE_W]}; // RL4
    end
  endgenerate

  // Data is taken at the second taken edge after the command.
  wire write_beat = edge_taken && (op2_r == SBW_OP_WRITE); // RL13
  // A write with no lane selected completes its cycle but stores nothing.
  wire write_stores = write_beat && (sel2_r != SBW_LANES_NONE_N); // RL2 RL5
  assign push_entry = {addr2_r, sel2_r, pin_word};

  // Reads about to access storage hold the drain off, so the buffer can fill.
  wire drain_ready = (op1_r != SBW_OP_READ);

  sbw_fifo #(
    .WIDTH(SBW_ENTRY_W),
    .DEPTH(SBW_FIFO_DEPTH)
  ) u_wbuf (
    .clock(clock),
    .rst_n(rst_n_r),
    .in_valid(write_stores),
    .in_ready(fifo_in_ready),
    .in_data(push_entry),
    .out_valid(fifo_out_valid),
    .out_ready(drain_ready),
    .out_data(pop_entry)
  );

  // ---------------------------------------------------------------
  // Storage with per-lane write gating
  // ---------------------------------------------------------------
  logic [SBW_WORD_W-1:0] mem_r [SBW_DEPTH];

  wire drain = fifo_out_valid && drain_ready;
  wire [SBW_ADDR_W-1:0] drain_addr = pop_entry[SBW_ENTRY_W-1 -: SBW_ADDR_W];
  wire [SBW_LANES-1:0] drain_sel_n = pop_entry[SBW_WORD_W +: SBW_LANES];
  wire [SBW_WORD_W-1:0] drain_word = pop_entry[SBW_WORD_W-1:0];

  generate
    for (g = 0; g < SBW_LANES; g++)
    begin : g_lane
      // Only a low select touches its lane; the others keep old contents.
      wire lane_we = drain && !drain_sel_n[g]; // RL3 RL4 RL15
      always_ff @(posedge clock)
      begin
        if (lane_we)
          mem_r[drain_addr][g*SBW_LANE_W +: SBW_LANE_W] <=
            drain_word[g*SBW_LANE_W +: SBW_LANE_W]; // RL4
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // Read data and pin drive
  // ---------------------------------------------------------------
  logic [SBW_WORD_W-1:0] read_word_r;
  logic read_drive_r;
  logic full_r;
  logic [SBW_DATA_W-1:0] rd_data;
  logic [SBW_LANES-1:0] rd_parity;

  // Reads do not see writes still waiting in the buffer; a controller
  // re-reading a just-written word must allow the buffer to drain first.
  always_ff @(posedge clock or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      read_word_r <= SBW_WORD_RESET;
      read_drive_r <= 1'b0; // RL9
      full_r <= 1'b0;
    end
    else
    begin
      full_r <= !fifo_in_ready;
      if (edge_taken) // RL8
      begin
        // Drive only in a read data phase; write and deselect phases float.
        read_drive_r <= (op2_r == SBW_OP_READ); // RL6 RL7 RL12
        if (op2_r == SBW_OP_READ)
          read_word_r <= mem_r[addr2_r];
      end
    end
  end

  generate
    for (g = 0; g < SBW_LANES; g++)
    begin : g_unpack
      assign rd_data[g*SBW_BYTE_W +: SBW_BYTE_W] =
        read_word_r[g*SBW_LANE_W +: SBW_BYTE_W];
      assign rd_parity[g] = read_word_r[g*SBW_LANE_W + SBW_BYTE_W];
    end
  endgenerate

  assign data_pins_out = rd_data;
  assign parity_pins_out = rd_parity;
  // Output enable gates the registered drive without a clock; the drive
  // term is already low in write phases, which masks it there.
  assign data_pins_oe = read_drive_r && !output_enable_n; // RL10 RL11 RL12
  assign write_buffer_full = full_r;

endmodule // sbw_core
`default_nettype wire

// ==== dv/sbw_core_asserts.sv ====
// Purpose: Pin-level timing checks of the byte-write control block.
// Assumes: Commands are tracked only on edges taken with the clock qualifier low.
// Notes:   Bound to sbw_core below.
`timescale 1ns/1ns
`default_nettype none
module sbw_core_asserts
(
  // Clock and reset.
  input wire logic clock,
  input wire logic arst_n,
  // Command pins.
  input wire logic clock_qualifier_n,
  input wire logic chip_enable_n,
  input wire logic advance_or_load,
  input wire logic write_request_n,
  input wire logic output_enable_n,
  // Data side.
  input wire logic [sbw_pkg::SBW_DATA_W-1:0] data_pins_out,
  input wire logic [sbw_pkg::SBW_LANES-1:0] parity_pins_out,
  input wire logic data_pins_oe,
  input wire logic write_buffer_full
);
  import sbw_pkg::*;
  logic [2:0] rd_r;
  logic [2:0] wr_r;
  logic rd_nxt;
  logic wr_nxt;
  // A burst beat keeps the operation of the beat before it.
  assign rd_nxt = advance_or_load ? rd_r[0] : !chip_enable_n && write_request_n;
  assign wr_nxt = advance_or_load ? wr_r[0] : !chip_enable_n && !write_request_n;
  always_ff @(posedge clock or negedge arst_n)
    if (!arst_n)
    begin
      rd_r <= 3'h0;
      wr_r <= 3'h0;
    end
    else if (!clock_qualifier_n)
    begin
      rd_r <= {rd_r[1:0], rd_nxt};
      wr_r <= {wr_r[1:0], wr_nxt};
    end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_read_drive; rd_r[2] && !output_enable_n |-> data_pins_oe; endproperty
  a_read_drive: assert property (p_read_drive) else $error("read data not driven");
  property p_idle_float; !rd_r[2] |-> !data_pins_oe; endproperty
  a_idle_float: assert property (p_idle_float) else $error("pins driven off a read");
  property p_write_float; wr_r[2] |-> !data_pins_oe; endproperty
  a_write_float: assert property (p_write_float) else $error("pins driven in write");
  property p_oe_masked; output_enable_n |-> !data_pins_oe; endproperty
  a_oe_masked: assert property (p_oe_masked) else $error("drive with oe off");
  property p_stall_hold; clock_qualifier_n |=> $stable({data_pins_out, parity_pins_out}); endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("data moved on stall");
  property p_stall_drive;
    clock_qualifier_n ##1 $stable(output_enable_n) |-> $stable(data_pins_oe);
  endproperty
  a_stall_drive: assert property (p_stall_drive) else $error("drive moved on stall");
  property p_power_up; $rose(arst_n) |-> (!data_pins_oe && !write_buffer_full) [*3]; endproperty
  a_power_up: assert property (p_power_up) else $error("pins driven after reset");
  property p_out_read; $changed({data_pins_out, parity_pins_out}) |-> rd_r[2]; endproperty
  a_out_read: assert property (p_out_read) else $error("data changed off a read");
endmodule // sbw_core_asserts
bind sbw_core sbw_core_asserts chk_u (.clock(clock), .arst_n(arst_n),
  .clock_qualifier_n(clock_qualifier_n), .chip_enable_n(chip_enable_n),
  .advance_or_load(advance_or_load), .write_request_n(write_request_n),
  .output_enable_n(output_enable_n), .data_pins_out(data_pins_out),
  .parity_pins_out(parity_pins_out), .data_pins_oe(data_pins_oe),
  .write_buffer_full(write_buffer_full));
`default_nettype wire

// ==== dv/sbw_ctl_model.sv ====
// Purpose: Memory controller model driving command and data pins.
// Assumes: One beat per call; write data goes out two taken edges later.
// Notes:   Undriven lines toggle, since no pull resistor holds them.
`timescale 1ns/1ns
`default_nettype none
module sbw_ctl_model
(
  // Clock.
  input wire logic clock,
  // Command pins.
  output logic clock_qualifier_n,
  output logic chip_enable_n,
  output logic advance_or_load,
  output logic write_request_n,
  output logic [sbw_pkg::SBW_LANES-1:0] lane_write_selects_n,
  output logic [sbw_pkg::SBW_ADDR_W-1:0] address,
  output logic output_enable_n,
  // Data lines.
  input wire logic [sbw_pkg::SBW_DATA_W-1:0] data_pins_out,
  input wire logic [sbw_pkg::SBW_LANES-1:0] parity_pins_out,
  input wire logic data_pins_oe,
  output logic [sbw_pkg::SBW_WORD_W-1:0] bus
);
  import sbw_pkg::*;
  logic [SBW_WORD_W-1:0] s0, s1, wd, last;
  logic v0, v1, drv;
  assign bus = data_pins_oe ? {parity_pins_out, data_pins_out} : drv ? wd : ~last;
  always @(posedge clock) last <= bus;
  initial
  begin
    {v0, v1, drv, s0, s1, wd, last} = '0;
    {clock_qualifier_n, chip_enable_n, write_request_n, output_enable_n} = 4'h6;
    lane_write_selects_n = 4'hF;
    advance_or_load = 1'b0;
    address = 4'h0;
  end
  task automatic beat(input logic ce_n, input logic wr_n, input logic [3:0] sel_n,
    input logic [3:0] adr, input logic [35:0] w);
    @(negedge clock);
    {drv, wd} = {v1, s1};
    {v1, s1} = {v0, s0};
    {v0, s0} = {!ce_n && !wr_n, w};
    clock_qualifier_n = 1'b0;
    chip_enable_n = ce_n;
    write_request_n = wr_n;
    lane_write_selects_n = sel_n;
    address = adr;
  endtask
  task automatic hold(input int n);
    @(negedge clock);
    clock_qualifier_n = 1'b1;
    repeat (n - 1) @(negedge clock);
  endtask
endmodule // sbw_ctl_model
`default_nettype wire

// ==== dv/sbw_core_test.sv ====
// Purpose: Self-checking bench of the byte-write control block.
// Assumes: Controller model drives all pins on the falling edge, except output enable, which t_oe also toggles between edges.
// Notes:   The write buffer drains as fast as the pins fill it, so full is never reached.
`timescale 1ns/1ns
`default_nettype none
module sbw_core_test;
  import sbw_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  int n_fail = 0;
  int checks_done = 0;
  logic [35:0] bus, base;
  logic cq_n, ce_n, wr_n, oe_n, oe, full;
  logic adv;
  logic [3:0] sel_n, po, adr;
  logic [31:0] dout;
  always #20 clock = ~clock;
  sbw_ctl_model ctl_u (.clock(clock), .clock_qualifier_n(cq_n), .chip_enable_n(ce_n),
    .advance_or_load(adv),
    .write_request_n(wr_n), .lane_write_selects_n(sel_n), .address(adr),
    .output_enable_n(oe_n), .data_pins_out(dout), .parity_pins_out(po),
    .data_pins_oe(oe), .bus(bus));
  sbw_core dut_u (.clock(clock), .arst_n(arst_n), .clock_qualifier_n(cq_n),
    .chip_enable_n(ce_n), .advance_or_load(adv), .write_request_n(wr_n),
    .lane_write_selects_n(sel_n), .address(adr), .output_enable_n(oe_n),
    .data_pins_in(bus[31:0]), .parity_pins_in(bus[35:32]), .data_pins_out(dout),
    .parity_pins_out(po), .data_pins_oe(oe), .write_buffer_full(full));
  task automatic test_done;
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: flag %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic chk36(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [35:0] merge(input logic [35:0] o, n, input logic [3:0] s);
    merge = o;
    for (int g = 0; g < 4; g++)
      if (!s[g])
      begin
        merge[8*g+:8] = n[8*g+:8];
        merge[32+g] = n[32+g];
      end
  endfunction
  task automatic idle(input int n);
    repeat (n) ctl_u.beat(1'b1, 1'b1, 4'hF, 4'h0, 36'h0);
  endtask
  task automatic wr(input logic [3:0] a, input logic [3:0] s, input logic [35:0] w);
    ctl_u.beat(1'b0, 1'b0, s, a, w);
    idle(2);
    @(posedge clock);
    #1;
    chk1(oe, 1'b0);
    idle(3);
  endtask
  task automatic rd(input logic [3:0] a, input logic [35:0] exp, input int st);
    ctl_u.beat(1'b0, 1'b1, 4'h0, a, 36'h0);
    if (st > 0)
      ctl_u.hold(st);
    idle(2);
    @(posedge clock);
    #1;
    chk1(oe, !oe_n);
    if (!oe_n)
      chk36(bus, exp);
    ctl_u.hold(2);
    if (!oe_n)
      chk36(bus, exp);
  endtask
  task automatic t_lanes;
    for (int p = 0; p < 16; p++)
    begin
      base = {4'(p), 32'h13579BDF ^ {8{4'(p)}}};
      wr(4'h3, 4'h0, base);
      wr(4'h3, 4'(p), ~base);
      rd(4'h3, merge(base, ~base, 4'(p)), p % 3);
    end
    $display("t_lanes done");
  endtask
  task automatic t_oe;
    wr(4'h7, 4'h0, 36'h987654321);
    rd(4'h7, 36'h987654321, 0);
    #5 ctl_u.output_enable_n = 1'b1;
    #1 chk1(oe, 1'b0);
    #1 ctl_u.output_enable_n = 1'b0;
    #1 chk1(oe, 1'b1);
    ctl_u.output_enable_n = 1'b1;
    rd(4'h7, 36'h0, 1);
    ctl_u.output_enable_n = 1'b0;
    $display("t_oe done");
  endtask
  task automatic t_b2b;
    for (int i = 0; i < 4; i++)
      ctl_u.beat(1'b0, 1'b0, 4'h0, 4'(8 + i), {4'(i), 32'hC0DE0000 + 32'(i)});
    idle(6);
    chk1(full, 1'b0);
    for (int i = 0; i < 6; i++)
    begin
      ctl_u.beat(i > 3, 1'b1, 4'(i), 4'(8 + i), 36'h0);
      @(posedge clock);
      #1;
      if (i > 1)
        chk36(bus, {4'(i - 2), 32'hC0DE0000 + 32'(i - 2)});
    end
    rd(4'h8, 36'h0C0DE0000, 0);
    $display("t_b2b done");
  endtask
  // Clears word 5, writes word 4, then burst beats to word 5 with lane selects 5 and to word 6; reads back words 4 to 6.
  task automatic t_burst;
    wr(4'h5, 4'h0, 36'h0);
    ctl_u.beat(1'b0, 1'b0, 4'h0, 4'h4, 36'h1A1A1A1A1);
    ctl_u.beat(1'b0, 1'b0, 4'h5, 4'h0, 36'h2B2B2B2B2);
    ctl_u.advance_or_load = 1'b1;
    ctl_u.beat(1'b0, 1'b0, 4'h0, 4'h0, 36'h3C3C3C3C3);
    idle(1);
    ctl_u.advance_or_load = 1'b0;
    idle(4);
    rd(4'h4, 36'h1A1A1A1A1, 0);
    rd(4'h5, merge(36'h0, 36'h2B2B2B2B2, 4'h5), 0);
    rd(4'h6, 36'h3C3C3C3C3, 0);
    $display("t_burst done");
  endtask
  initial
  begin
    repeat (5) @(posedge clock);
    @(negedge clock);
    arst_n = 1'b1;
    idle(3);
    chk1(oe, 1'b0);
    t_lanes;
    t_oe;
    t_b2b;
    t_burst;
    test_done;
  end
  initial
  begin
    #(40 * 5000);
    n_fail++;
    test_done;
  end
endmodule // sbw_core_test
`default_nettype wire
